// [sys_regs_pkg.sv]
// Purpose: Shared constants for the clock, flag and combiner register bank.
// Assumes: 32-bit AXI4-Lite data, one aligned word per register.
// Notes:   Offsets are byte addresses.
package sys_regs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  CLKDIV_OFS    = 8'h20;
  localparam logic [7:0]  FLAGS_OFS     = 8'h24;
  localparam logic [7:0]  COMB_OFS      = 8'h28;
  localparam logic [7:0]  IRQ_MASK_OFS  = 8'h2C;

  // ****************************************************************
  // Field layout and reset values
  // ****************************************************************
  localparam int          CORE_DIV_LSB  = 28;
  localparam int          BUS_DIV_BIT   = 24;
  localparam int          TIMER_DIV_BIT = 20;
  localparam logic [31:0] CLKDIV_WMASK  = 32'h3110_0000;
  localparam logic [31:0] FLAGS_WMASK   = 32'h0000_0003;
  localparam logic [31:0] CLKDIV_INIT   = 32'h0000_0000;
  localparam logic [31:0] COMB_RESET    = 32'h0000_0000;
  localparam logic [1:0]  MASK_RESET    = 2'h0;
  localparam int          FLAG_CLAMP    = 0;
  localparam int          FLAG_SHUT     = 1;

  // ****************************************************************
  // Combiner field codes and bus responses
  // ****************************************************************
  localparam logic [1:0]  CFG_ZERO      = 2'h0;
  localparam logic [1:0]  CFG_PASS      = 2'h1;
  localparam logic [1:0]  CFG_INVERT    = 2'h2;
  localparam logic [1:0]  CFG_ONE       = 2'h3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

endpackage : sys_regs_pkg

// [system_clock_flag_logic_regs.sv]
// Purpose: Clock divider, clamp/shutdown flags and logic combiner registers.
// Assumes: Source clock is aclk; derived clocks are one-cycle enables.
// Notes:   Divider register keeps its contents across reset.
//
// Overview of operation
// R1: Core clock enable divides source by 1, 2, 3 or 4 from bits 29-28.
// R2: Bus clock enable follows core enable, halved when bit 24 is one.
// R3: Timer clock enable is source rate, or halved when bit 20 is one.
// R4: Divider fields keep their contents through reset.
// R5: Software keeps the bus clock at or below 24 MHz.
// R6: Divider reserved bits read zero and ignore writes.
// R7: Flag bit 1 shows regulator shutdown and drives its request output.
// R8: Writing one clears the shutdown flag; zero leaves it alone.
// R9: Flag bit 0 shows external clamp and drives the clamp output.
// R10: Writing one clears clamp flag; zero does nothing; bits 31-2 read zero.
// R11: Sixteen 2-bit fields, term 0 input A at 31-30 down to term 3 D.
// R12: Field codes force zero, pass, complement or force one.
// R13: Each term ANDs its four inputs; output ORs the four terms.
// R14: Combiner fields reset to zero.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
module system_clock_flag_logic_regs (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        clamp_event_in,
  input  wire logic        shutdown_event_in,
  input  wire logic [15:0] combiner_in,
  output logic             core_clk_en,
  output logic             bus_clk_en,
  output logic             timer_clk_en,
  output logic             external_clamp_out,
  output logic             regulator_shutdown_req,
  output logic             combiner_out,
  output logic             irq
);
  import sys_regs_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic        aw_full;
    logic [31:0] aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [31:0] clkdiv;
    logic [31:0] comb_cfg;
    logic [1:0]  flags;
    logic [1:0]  irq_mask;
    logic [1:0]  evt_meta;
    logic [1:0]  evt_sync;
    logic [1:0]  cnt;
    logic        bus_phase;
    logic        timer_phase;
    logic        core_en;
    logic        bus_en;
    logic        timer_en;
    logic        comb_out;
    logic        irq;
  } state_t;

  state_t st_q = '0;
  state_t st_d;
  state_t st_rst;
  logic   wr_go;
  logic   wr_flags;
  logic   core_hit;
  logic [1:0] flag_clr;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  strb,
                                        input logic [31:0] wmask);
    logic [31:0] bm;
    bm = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & wmask;
    return (old & ~bm) | (wd & bm);
  endfunction : merge

  function automatic logic combine(input logic [31:0] cfg,
                                   input logic [15:0] din);
    logic [15:0] sel;
    logic        res;
    res = 1'b0;
    for (int k = 0; k < 16; k++) begin
      case (cfg[2*k +: 2])
        CFG_ZERO:   sel[k] = 1'b0;
        CFG_PASS:   sel[k] = din[k];
        CFG_INVERT: sel[k] = ~din[k];
        default:    sel[k] = 1'b1;
      endcase
    end
    for (int t = 0; t < 4; t++) begin
      res = res | (&sel[15-4*t -: 4]);
    end
    return res;
  endfunction : combine

  function automatic logic [31:0] read_mux(input state_t s,
                                           input logic [7:0] a);
    case (a)
      CLKDIV_OFS:   return s.clkdiv & CLKDIV_WMASK;
      FLAGS_OFS:    return {30'h0000_0000, s.flags};
      COMB_OFS:     return s.comb_cfg;
      IRQ_MASK_OFS: return {30'h0000_0000, s.irq_mask};
      default:      return 32'h0000_0000;
    endcase
  endfunction : read_mux

  function automatic logic mapped(input logic [31:0] a);
    return a[31:8] == 24'h00_0000 && (a[7:0] == CLKDIV_OFS ||
           a[7:0] == FLAGS_OFS || a[7:0] == COMB_OFS ||
           a[7:0] == IRQ_MASK_OFS);
  endfunction : mapped

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    // Bus write path: address and data are taken in either order.
    if (awvalid && st_q.awready) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && st_q.wready) begin
      st_d.w_full = 1'b1;
      st_d.w_data = wdata;
      st_d.w_strb = wstrb;
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
    end
    wr_go = st_q.aw_full && st_q.w_full;
    wr_flags = wr_go && st_q.aw_addr == {24'h00_0000, FLAGS_OFS};
    flag_clr = 2'h0;
    if (wr_go) begin
      st_d.aw_full = 1'b0;
      st_d.w_full = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = mapped(st_q.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (st_q.aw_addr[31:8] == 24'h00_0000) begin
        case (st_q.aw_addr[7:0])
          CLKDIV_OFS: begin
            st_d.clkdiv = merge(st_q.clkdiv, st_q.w_data, st_q.w_strb,
                                CLKDIV_WMASK); // R6
          end
          FLAGS_OFS: begin
            if (st_q.w_strb[0]) begin
              flag_clr = st_q.w_data[1:0]; // R8 R10
            end
          end
          COMB_OFS: begin
            st_d.comb_cfg = merge(st_q.comb_cfg, st_q.w_data, st_q.w_strb,
                                  32'hFFFF_FFFF); // R11
          end
          IRQ_MASK_OFS: begin
            if (st_q.w_strb[0]) begin
              st_d.irq_mask = st_q.w_data[1:0];
            end
          end
          default: begin
          end
        endcase
      end
    end
    st_d.awready = !st_d.aw_full && !st_d.bvalid;
    st_d.wready = !st_d.w_full && !st_d.bvalid;
    // Bus read path: one read at a time, data one cycle after address.
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
    end
    if (arvalid && st_q.arready) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = (araddr[31:8] == 24'h00_0000) ?
                   read_mux(st_q, araddr[7:0]) : 32'h0000_0000; // R6 R10
      st_d.rresp = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    st_d.arready = !st_d.rvalid;
    // Event pins pass two flip-flops; a set beats a clear.
    st_d.evt_meta = {shutdown_event_in, clamp_event_in};
    st_d.evt_sync = st_q.evt_meta;
    st_d.flags = (st_q.flags & ~flag_clr) | st_q.evt_sync; // R7 R8 R9 R10
    st_d.irq = |(st_d.flags & st_d.irq_mask);
    // Clock enables derived from the source clock.
    core_hit = st_q.cnt >= st_q.clkdiv[CORE_DIV_LSB +: 2];
    st_d.cnt = core_hit ? 2'h0 : st_q.cnt + 2'h1; // R1
    st_d.core_en = core_hit; // R1
    st_d.bus_phase = core_hit ? ~st_q.bus_phase : st_q.bus_phase;
    st_d.bus_en = core_hit &&
                  (!st_q.clkdiv[BUS_DIV_BIT] || st_q.bus_phase); // R2
    st_d.timer_phase = ~st_q.timer_phase;
    st_d.timer_en = !st_q.clkdiv[TIMER_DIV_BIT] || st_q.timer_phase; // R3
    st_d.comb_out = combine(st_q.comb_cfg, combiner_in); // R12 R13
    // Reset value keeps the divider register as it stands.
    st_rst = '0;
    st_rst.clkdiv = st_q.clkdiv; // R4
    st_rst.comb_cfg = COMB_RESET; // R14
    st_rst.irq_mask = MASK_RESET;
  end

  always_ff @(posedge aclk) begin
    st_q <= aresetn ? st_d : st_rst;
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign awready                = st_q.awready;
  assign wready                 = st_q.wready;
  assign bvalid                 = st_q.bvalid;
  assign bresp                  = st_q.bresp;
  assign arready                = st_q.arready;
  assign rvalid                 = st_q.rvalid;
  assign rdata                  = st_q.rdata;
  assign rresp                  = st_q.rresp;
  assign core_clk_en            = st_q.core_en;
  assign bus_clk_en             = st_q.bus_en;
  assign timer_clk_en           = st_q.timer_en;
  assign external_clamp_out     = st_q.flags[FLAG_CLAMP]; // R9
  assign regulator_shutdown_req = st_q.flags[FLAG_SHUT]; // R7
  assign combiner_out           = st_q.comb_out;
  assign irq                    = st_q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_CORE_PULSE: assert property ( // R1
    $past(aresetn) |-> core_clk_en ==
      ($past(st_q.cnt) >= $past(st_q.clkdiv[29:28])))
    else $error("Core enable does not match divider count.");
  AST_CORE_DIV4: assert property ( // R1
    core_clk_en && st_q.clkdiv[29:28] == 2'h3 ##1
      st_q.clkdiv[29:28] == 2'h3 |-> !core_clk_en ##1 !core_clk_en)
    else $error("Core enable too early for divide by four.");
  AST_BUS_FOLLOWS: assert property ( // R2
    bus_clk_en |-> core_clk_en)
    else $error("Bus enable without core enable.");
  AST_BUS_UNDIV: assert property ( // R2
    core_clk_en && $past(aresetn) && !$past(st_q.clkdiv[24]) |-> bus_clk_en)
    else $error("Bus enable missing while undivided.");
  AST_TIMER_RATE: assert property ( // R3
    $past(aresetn) && !$past(st_q.clkdiv[20]) |-> timer_clk_en)
    else $error("Timer enable missing at source rate.");
  AST_TIMER_HALF: assert property ( // R3
    st_q.clkdiv[20] ##1 st_q.clkdiv[20] ##1 (timer_clk_en && st_q.clkdiv[20])
      |=> !timer_clk_en)
    else $error("Timer enable not halved.");
  AST_DIV_KEEP: assert property (@(posedge aclk) disable iff (1'b0) // R4
    !aresetn |=> $stable(st_q.clkdiv))
    else $error("Divider changed by reset.");
  AST_DIV_RSV: assert property ( // R6
    (st_q.clkdiv & ~CLKDIV_WMASK) == 32'h0000_0000)
    else $error("Divider reserved bits set.");
  AST_SHUT_SET: assert property ( // R7
    shutdown_event_in [*3] |-> ##2 regulator_shutdown_req)
    else $error("Shutdown flag not set by event.");
  AST_SHUT_CLR: assert property ( // R8
    wr_flags && st_q.w_strb[0] && st_q.w_data[1] && !st_q.evt_sync[1]
      |=> !regulator_shutdown_req)
    else $error("Shutdown flag not cleared.");
  AST_CLAMP_SET: assert property ( // R9
    clamp_event_in [*3] |-> ##2 external_clamp_out)
    else $error("Clamp flag not set by event.");
  AST_CLAMP_KEEP: assert property ( // R10
    external_clamp_out && !(wr_flags && st_q.w_strb[0] && st_q.w_data[0])
      |=> external_clamp_out)
    else $error("Clamp flag lost without a clear.");
  AST_COMB_ONE: assert property ( // R12
    st_q.comb_cfg[31:24] == 8'hFF |=> combiner_out)
    else $error("Forced-one term does not drive output.");
  AST_COMB_ZERO: assert property ( // R13
    st_q.comb_cfg == 32'h0000_0000 |=> !combiner_out)
    else $error("Output high with all inputs forced zero.");
  AST_COMB_RESET: assert property (@(posedge aclk) disable iff (1'b0) // R14
    !aresetn |=> st_q.comb_cfg == 32'h0000_0000)
    else $error("Combiner fields not cleared by reset.");

  COV_WRITE: cover property (bvalid && bready && bresp == RESP_OKAY);
  COV_READ:  cover property (rvalid && rready && rdata != 32'h0000_0000);
  COV_IRQ:   cover property ($rose(irq));

endmodule : system_clock_flag_logic_regs

// [testbench.sv]
// Purpose: Self-checking bench for the clock, flag and combiner registers.
// Assumes: 250 MHz aclk, synchronous active-low reset held 16 cycles.
// Notes:   Drives the AXI4-Lite slave port directly with tasks.
`timescale 1ns/1ns
module testbench;
  import sys_regs_pkg::*;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic        clamp_event_in, shutdown_event_in, combiner_out;
  logic        core_clk_en, bus_clk_en, timer_clk_en;
  logic        external_clamp_out, regulator_shutdown_req;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [15:0] combiner_in;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          error_cnt, comparisons;
  int          cycles = 0;
  int          nc, nb, nt;
  logic [31:0] cfg_tab [8] = '{32'h0, 32'hFF00_0000, 32'h5500_0000,
    32'h5500_0000, 32'hAA00_0000, 32'hAA00_0000, 32'h0096_0000, 32'h3FFF_FFFF};
  logic [15:0] in_tab [8] = '{16'hFFFF, 16'h0000, 16'hF000, 16'hE000,
    16'h0000, 16'h1000, 16'h0600, 16'hFFFF};

  system_clock_flag_logic_regs u_system_clock_flag_logic_regs (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .clamp_event_in(clamp_event_in),
    .shutdown_event_in(shutdown_event_in), .combiner_in(combiner_in),
    .core_clk_en(core_clk_en), .bus_clk_en(bus_clk_en),
    .timer_clk_en(timer_clk_en), .external_clamp_out(external_clamp_out),
    .regulator_shutdown_req(regulator_shutdown_req),
    .combiner_out(combiner_out), .irq(irq));

  // ****************************************************************
  // Clock, timeout and tasks
  // ****************************************************************
  always #2 aclk = ~aclk;

  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("[FAIL] run expected done seen timeout");
      results();
    end
  end

  task automatic results();
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : wait_cyc

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    bit aw_done;
    bit w_done;
    aw_done = 0;
    w_done = 0;
    awaddr <= {24'h0, a};
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!aw_done && awready) begin
        aw_done = 1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready) begin
        w_done = 1;
        wvalid <= 1'b0;
      end
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a);
    bit ar_done;
    ar_done = 0;
    araddr <= {24'h0, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (!ar_done && arready) begin
        ar_done = 1;
        arvalid <= 1'b0;
      end
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_rd

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    axi_rd(a);
    chk("read data", e, rd);
    chk("read resp", {30'h0, RESP_OKAY}, {30'h0, rs});
  endtask : rchk

  task automatic count_en();
    nc = 0;
    nb = 0;
    nt = 0;
    repeat (24) begin
      @(posedge aclk);
      nc += int'(core_clk_en === 1'b1);
      nb += int'(bus_clk_en === 1'b1);
      nt += int'(timer_clk_en === 1'b1);
    end
  endtask : count_en

  function automatic logic comb_exp(input logic [31:0] c,
                                    input logic [15:0] x);
    logic [3:0] t;
    logic       v;
    t = 4'hF;
    for (int k = 0; k < 16; k++) begin
      case (c[2*k+:2])
        2'h0: v = 1'b0;
        2'h1: v = x[k];
        2'h2: v = ~x[k];
        default: v = 1'b1;
      endcase
      t[k/4] = t[k/4] & v;
    end
    return |t;
  endfunction : comb_exp

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, wdata, araddr, wstrb, combiner_in} = '0;
    {clamp_event_in, shutdown_event_in, error_cnt, comparisons} = '0;
    wait_cyc(16);
    aresetn <= 1'b1;
    wait_cyc(1);
    rchk(CLKDIV_OFS, CLKDIV_INIT);
    rchk(COMB_OFS, COMB_RESET);
    rchk(FLAGS_OFS, 32'h0);
    axi_wr(CLKDIV_OFS, 32'hFFFF_FFFF);
    rchk(CLKDIV_OFS, CLKDIV_WMASK);
    for (int k = 0; k < 4; k++) begin
      axi_wr(CLKDIV_OFS, (k << 28) | ((k & 1) << 24) | ((k >> 1) << 20));
      wait_cyc(8);
      count_en();
      chk("core pulses", 24 / (k + 1), nc);
      chk("bus pulses", (24 / (k + 1)) >> (k & 1), nb);
      chk("timer pulses", (k >> 1) ? 12 : 24, nt);
    end
    axi_wr(CLKDIV_OFS, 32'h2010_0000);
    aresetn <= 1'b0;
    wait_cyc(2);
    aresetn <= 1'b1;
    wait_cyc(1);
    rchk(CLKDIV_OFS, 32'h2010_0000);
    clamp_event_in <= 1'b1;
    wait_cyc(3);
    clamp_event_in <= 1'b0;
    wait_cyc(6);
    rchk(FLAGS_OFS, 32'h1);
    chk("clamp out", 1, external_clamp_out);
    chk("irq masked", 0, irq);
    axi_wr(FLAGS_OFS, 32'h0);
    rchk(FLAGS_OFS, 32'h1);
    axi_wr(IRQ_MASK_OFS, 32'h3);
    wait_cyc(2);
    chk("irq", 1, irq);
    shutdown_event_in <= 1'b1;
    wait_cyc(3);
    shutdown_event_in <= 1'b0;
    wait_cyc(6);
    rchk(FLAGS_OFS, 32'h3);
    chk("shutdown req", 1, regulator_shutdown_req);
    axi_wr(FLAGS_OFS, 32'h1);
    wait_cyc(2);
    rchk(FLAGS_OFS, 32'h2);
    chk("clamp out", 0, external_clamp_out);
    chk("irq", 1, irq);
    axi_wr(FLAGS_OFS, 32'h2);
    wait_cyc(2);
    rchk(FLAGS_OFS, 32'h0);
    chk("shutdown req", 0, regulator_shutdown_req);
    chk("irq", 0, irq);
    clamp_event_in <= 1'b1;
    wait_cyc(4);
    axi_wr(FLAGS_OFS, 32'h1);
    rchk(FLAGS_OFS, 32'h1);
    clamp_event_in <= 1'b0;
    wait_cyc(4);
    axi_wr(FLAGS_OFS, 32'h1);
    rchk(FLAGS_OFS, 32'h0);
    for (int i = 0; i < 8; i++) begin
      axi_wr(COMB_OFS, cfg_tab[i]);
      combiner_in <= in_tab[i];
      wait_cyc(3);
      chk("comb", comb_exp(cfg_tab[i], in_tab[i]), combiner_out);
      rchk(COMB_OFS, cfg_tab[i]);
    end
    axi_wr(8'h30, 32'h1);
    chk("unmapped bresp", RESP_SLVERR, rs);
    axi_rd(8'h30);
    chk("unmapped rdata", 32'h0, rd);
    chk("unmapped rresp", RESP_SLVERR, rs);
    aresetn <= 1'b0;
    wait_cyc(2);
    aresetn <= 1'b1;
    wait_cyc(1);
    rchk(COMB_OFS, COMB_RESET);
    rchk(CLKDIV_OFS, 32'h2010_0000);
    results();
  end
endmodule : testbench
